//--- hdl/nvmsc_host.sv
`timescale 1ns/100ps
module nvmsc_host (
    nvmsc_if.host bus,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    // ****************************************************
    // Registers and AXI4-Lite slave
    // ****************************************************
    logic [8:0] cmd_reg, cmd_next;
    logic [15:0] wd_reg, wd_next;
    logic [15:0] rd_reg, rd_next;
    logic [1:0] st_reg, st_next;
    logic [1:0] mask_reg, mask_next;
    logic req_reg, req_next;
    logic awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next;
    logic [1:0] bresp_reg, bresp_next;
    logic [7:0] aw_reg, aw_next;
    logic [31:0] w_reg, w_next;
    logic strb_reg, strb_next;
    logic have_aw_reg, have_aw_next, have_w_reg, have_w_next;
    logic arr_reg, arr_next, rv_reg, rv_next;
    logic [31:0] r_reg, r_next;
    logic [1:0] rresp_reg, rresp_next;
    logic irq_reg, irq_next;
    logic [1:0] ev;

    always_comb begin
        cmd_next = cmd_reg;
        wd_next = wd_reg;
        rd_next = rd_reg;
        mask_next = mask_reg;
        req_next = req_reg;
        ev = 2'b00;
        awr_next = !have_aw_reg && !bv_reg && !(s_axi_awvalid && awr_reg);
        wr_next = !have_w_reg && !bv_reg && !(s_axi_wvalid && wr_reg);
        have_aw_next = have_aw_reg || (s_axi_awvalid && awr_reg);
        have_w_next = have_w_reg || (s_axi_wvalid && wr_reg);
        aw_next = (s_axi_awvalid && awr_reg) ? s_axi_awaddr : aw_reg;
        w_next = (s_axi_wvalid && wr_reg) ? s_axi_wdata : w_reg;
        strb_next = (s_axi_wvalid && wr_reg) ? s_axi_wstrb[0] : strb_reg;
        bv_next = bv_reg && !s_axi_bready;
        bresp_next = bresp_reg;
        if (req_reg && bus.ack) begin
            req_next = 1'b0;
            if (bus.write) begin
                ev[nvmsc_pkg::EV_WRITE_DONE] = 1'b1;
            end else begin
                ev[nvmsc_pkg::EV_READ_DONE] = 1'b1;
                rd_next = bus.rdata;
            end
        end
        st_next = st_reg;
        if (have_aw_reg && have_w_reg && !bv_reg) begin
            have_aw_next = 1'b0;
            have_w_next = 1'b0;
            bv_next = 1'b1;
            bresp_next = nvmsc_pkg::AXI_OKAY;
            if (aw_reg == nvmsc_pkg::HOST_CMD_OFS) begin
                if (!req_reg && strb_reg) begin
                    cmd_next = w_reg[8:0];
                    req_next = 1'b1;
                end else begin
                    bresp_next = nvmsc_pkg::AXI_SLVERR;
                end
            end else if (aw_reg == nvmsc_pkg::HOST_WDATA_OFS) begin
                wd_next = w_reg[15:0];
            end else if (aw_reg == nvmsc_pkg::HOST_STATUS_OFS) begin
                st_next = st_reg & ~w_reg[1:0];
            end else if (aw_reg == nvmsc_pkg::HOST_MASK_OFS) begin
                mask_next = w_reg[1:0];
            end else if (aw_reg != nvmsc_pkg::HOST_RDATA_OFS && aw_reg != nvmsc_pkg::HOST_BUSY_OFS) begin
                bresp_next = nvmsc_pkg::AXI_SLVERR;
            end
        end
        st_next = st_next | ev;
        irq_next = |(st_next & mask_next);
        arr_next = !rv_reg && !(s_axi_arvalid && arr_reg);
        rv_next = rv_reg && !s_axi_rready;
        r_next = r_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && arr_reg) begin
            rv_next = 1'b1;
            rresp_next = nvmsc_pkg::AXI_OKAY;
            if (s_axi_araddr == nvmsc_pkg::HOST_CMD_OFS) begin
                r_next = {23'h0, cmd_reg};
            end else if (s_axi_araddr == nvmsc_pkg::HOST_WDATA_OFS) begin
                r_next = {16'h0, wd_reg};
            end else if (s_axi_araddr == nvmsc_pkg::HOST_RDATA_OFS) begin
                r_next = {16'h0, rd_reg};
            end else if (s_axi_araddr == nvmsc_pkg::HOST_STATUS_OFS) begin
                r_next = {30'h0, st_reg};
            end else if (s_axi_araddr == nvmsc_pkg::HOST_MASK_OFS) begin
                r_next = {30'h0, mask_reg};
            end else if (s_axi_araddr == nvmsc_pkg::HOST_BUSY_OFS) begin
                r_next = {31'h0, req_reg};
            end else begin
                r_next = 32'h0;
                rresp_next = nvmsc_pkg::AXI_SLVERR;
            end
        end
    end

    always_ff @(posedge bus.aclk) begin
        if (!bus.aresetn) begin
            cmd_reg <= 9'h000;
            wd_reg <= 16'h0000;
            rd_reg <= 16'h0000;
            st_reg <= 2'h0;
            mask_reg <= 2'h0;
            req_reg <= 1'b0;
            awr_reg <= 1'b0;
            wr_reg <= 1'b0;
            bv_reg <= 1'b0;
            bresp_reg <= 2'h0;
            aw_reg <= 8'h00;
            w_reg <= 32'h0;
            strb_reg <= 1'b0;
            have_aw_reg <= 1'b0;
            have_w_reg <= 1'b0;
            arr_reg <= 1'b0;
            rv_reg <= 1'b0;
            r_reg <= 32'h0;
            rresp_reg <= 2'h0;
            irq_reg <= 1'b0;
        end else begin
            cmd_reg <= cmd_next;
            wd_reg <= wd_next;
            rd_reg <= rd_next;
            st_reg <= st_next;
            mask_reg <= mask_next;
            req_reg <= req_next;
            awr_reg <= awr_next;
            wr_reg <= wr_next;
            bv_reg <= bv_next;
            bresp_reg <= bresp_next;
            aw_reg <= aw_next;
            w_reg <= w_next;
            strb_reg <= strb_next;
            have_aw_reg <= have_aw_next;
            have_w_reg <= have_w_next;
            arr_reg <= arr_next;
            rv_reg <= rv_next;
            r_reg <= r_next;
            rresp_reg <= rresp_next;
            irq_reg <= irq_next;
        end
    end

    // Software composes each word; preset use and bit 13 with 17h are its duty
    assign bus.req = req_reg;
    assign bus.write = cmd_reg[nvmsc_pkg::HOST_CMD_WRITE_BIT];
    assign bus.cmd = cmd_reg[7:0];
    assign bus.wdata = wd_reg;
    assign s_axi_awready = awr_reg;
    assign s_axi_wready = wr_reg;
    assign s_axi_bvalid = bv_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arr_reg;
    assign s_axi_rvalid = rv_reg;
    assign s_axi_rdata = r_reg;
    assign s_axi_rresp = rresp_reg;
    assign irq = irq_reg;
endmodule

//--- hdl/nvmsc_pkg.sv
package nvmsc_pkg;
    // ****************************************************
    // Command codes and register layout
    // ****************************************************
    localparam logic [7:0] CMD_STORE_CTRL = 8'h07;
    localparam logic [7:0] CMD_SPIKE_CTRL = 8'h08;
    localparam logic [7:0] CMD_CLEAR_LAST_FAULT = 8'hf3;
    localparam logic [7:0] CMD_CLEAR_STORE_FAULT = 8'hf4;
    localparam logic [15:0] STORE_CTRL_RESET = 16'h0000;
    localparam logic [15:0] SPIKE_CTRL_RESET = 16'h0000;
    localparam logic [7:0] FAULT_LOG_CLEAR = 8'h00;
    // Store control word bits
    localparam int USER_CHECK_BIT = 15;
    localparam int TRIM_CHECK_BIT = 14;
    localparam int WHOLE_CHECK_BIT = 13;
    localparam int STORE_BLOCK_BIT = 12;
    localparam int LAST_BLOCK_BIT = 11;
    localparam int EXCL_RECORD_BIT = 5;
    localparam int NO_FAULT_STORE_BIT = 4;
    localparam int SINGLE_RECORD_BIT = 3;
    localparam int RECORD_EN_BIT = 1;
    localparam int LIVE_READ_BIT = 0;
    // Spike control word fields
    localparam int SR_DELAY_MSB = 15;
    localparam int SR_DELAY_LSB = 12;
    localparam int MIN_ON_MSB = 11;
    localparam int MIN_ON_LSB = 8;
    localparam int SS_DELAY_BIT = 6;
    localparam int RUN_DELAY_BIT = 5;
    localparam int NORM_DELAY_BIT = 4;
    localparam int FORCE_SR_BIT = 3;
    localparam int SS_ADJ_BIT = 2;
    localparam int RUN_ADJ_BIT = 1;
    localparam int LOW_ADJ_BIT = 0;
    // Status / interrupt bits of the host controller
    localparam int EV_WRITE_DONE = 0;
    localparam int EV_READ_DONE = 1;
    localparam int EV_WIDTH = 2;
    // Host controller AXI4-Lite map
    localparam logic [7:0] HOST_CMD_OFS = 8'h00;
    localparam logic [7:0] HOST_WDATA_OFS = 8'h04;
    localparam logic [7:0] HOST_RDATA_OFS = 8'h08;
    localparam logic [7:0] HOST_STATUS_OFS = 8'h0c;
    localparam logic [7:0] HOST_MASK_OFS = 8'h10;
    localparam logic [7:0] HOST_BUSY_OFS = 8'h14;
    localparam int HOST_CMD_WRITE_BIT = 8;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

//--- hdl/nvmsc_if.sv
`timescale 1ns/100ps
interface nvmsc_if (
    input wire logic aclk,
    input wire logic aresetn
);
    // One word transaction per request; write or read back under a command code
    logic req;
    logic write;
    logic [7:0] cmd;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    modport device (input aclk, input aresetn, input req, input write, input cmd, input wdata,
        output ack, output rdata);
    modport host (input aclk, input aresetn, output req, output write, output cmd, output wdata,
        input ack, input rdata);
endinterface

//--- hdl/nvmsc_device.sv
`timescale 1ns/100ps
module nvmsc_device (
    nvmsc_if.device bus,
    input wire logic store_fault,
    input wire logic [7:0] last_fault_value,
    input wire logic [7:0] memory_pointer,
    input wire logic record_fault_trigger,
    input wire logic soft_start,
    input wire logic normal_run,
    input wire logic primary_on,
    input wire logic rectifier_on,
    input wire logic high_input_surge,
    input wire logic low_input_surge,
    output logic user_check_en,
    output logic trim_check_en,
    output logic whole_store_check_en,
    output logic exclude_record_from_check,
    output logic fault_record_en,
    output logic fault_record_single,
    output logic [7:0] fault_log_value,
    output logic live_store_read_en,
    output logic startup_blocked,
    output logic ontime_limit_active,
    output logic [4:0] surge_min_on_time,
    output logic rectifier_delay_active,
    output logic [3:0] rectifier_surge_delay,
    output logic force_rectifier_on,
    output logic shutdown_request
);
    // ****************************************************
    // Word registers
    // ****************************************************
    logic [15:0] store_ctrl_reg, store_ctrl_next;
    logic [15:0] spike_ctrl_reg, spike_ctrl_next;
    logic ack_reg, ack_next;
    logic [15:0] rdata_reg, rdata_next;
    logic store_block_reg, store_block_next;
    logic last_block_reg, last_block_next;

    always_comb begin
        store_ctrl_next = store_ctrl_reg;
        spike_ctrl_next = spike_ctrl_reg;
        ack_next = 1'b0;
        rdata_next = rdata_reg;
        if (bus.req && !ack_reg) begin
            ack_next = 1'b1;
            if (bus.write) begin
                if (bus.cmd == nvmsc_pkg::CMD_STORE_CTRL) begin
                    store_ctrl_next = bus.wdata;
                end else if (bus.cmd == nvmsc_pkg::CMD_SPIKE_CTRL) begin
                    spike_ctrl_next = bus.wdata;
                end
            end else begin
                if (bus.cmd == nvmsc_pkg::CMD_STORE_CTRL) begin
                    rdata_next = store_ctrl_reg;
                end else if (bus.cmd == nvmsc_pkg::CMD_SPIKE_CTRL) begin
                    rdata_next = spike_ctrl_reg;
                end else begin
                    rdata_next = 16'h0000;
                end
            end
        end
    end

    // ****************************************************
    // Start-up blocking
    // ****************************************************
    logic clr_store, clr_last;
    always_comb begin
        clr_store = bus.req && !ack_reg && bus.cmd == nvmsc_pkg::CMD_CLEAR_STORE_FAULT;
        clr_last = bus.req && !ack_reg && bus.cmd == nvmsc_pkg::CMD_CLEAR_LAST_FAULT;
        store_block_next = store_block_reg;
        last_block_next = last_block_reg;
        if (clr_store) begin
            store_block_next = 1'b0;
        end
        if (store_fault && store_ctrl_reg[nvmsc_pkg::STORE_BLOCK_BIT]) begin
            store_block_next = 1'b1;
        end
        if (clr_last) begin
            last_block_next = 1'b0;
        end
        if (last_fault_value != 8'h00 && store_ctrl_reg[nvmsc_pkg::LAST_BLOCK_BIT] && !last_block_reg
            && !clr_last) begin
            last_block_next = 1'b1;
        end
        if (!store_ctrl_reg[nvmsc_pkg::LAST_BLOCK_BIT]) begin
            last_block_next = 1'b0;
        end
    end

    always_ff @(posedge bus.aclk) begin
        if (!bus.aresetn) begin
            store_ctrl_reg <= nvmsc_pkg::STORE_CTRL_RESET;
            spike_ctrl_reg <= nvmsc_pkg::SPIKE_CTRL_RESET;
            ack_reg <= 1'b0;
            rdata_reg <= 16'h0000;
            store_block_reg <= 1'b0;
            last_block_reg <= 1'b0;
        end else begin
            store_ctrl_reg <= store_ctrl_next;
            spike_ctrl_reg <= spike_ctrl_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            store_block_reg <= store_block_next;
            last_block_reg <= last_block_next;
        end
    end

    assign bus.ack = ack_reg;
    assign bus.rdata = rdata_reg;

    // ****************************************************
    // Store and spike outputs
    // ****************************************************
    logic [7:0] log_next;
    logic high_adj, low_adj, dly_act, force_next;
    always_comb begin
        if (store_ctrl_reg[nvmsc_pkg::NO_FAULT_STORE_BIT]) begin
            log_next = nvmsc_pkg::FAULT_LOG_CLEAR;
        end else if (!record_fault_trigger) begin
            log_next = memory_pointer;
        end else begin
            log_next = last_fault_value;
        end
        high_adj = high_input_surge && ((soft_start && spike_ctrl_reg[nvmsc_pkg::SS_ADJ_BIT])
            || (!soft_start && spike_ctrl_reg[nvmsc_pkg::RUN_ADJ_BIT]));
        low_adj = low_input_surge && !soft_start && spike_ctrl_reg[nvmsc_pkg::LOW_ADJ_BIT];
        dly_act = high_input_surge && ((soft_start && spike_ctrl_reg[nvmsc_pkg::SS_DELAY_BIT])
            || (!soft_start && spike_ctrl_reg[nvmsc_pkg::RUN_DELAY_BIT])
            || (normal_run && spike_ctrl_reg[nvmsc_pkg::NORM_DELAY_BIT]
            && spike_ctrl_reg[nvmsc_pkg::RUN_DELAY_BIT]));
        force_next = spike_ctrl_reg[nvmsc_pkg::FORCE_SR_BIT] && primary_on && !rectifier_on
            && (high_input_surge || low_input_surge);
    end

    always_ff @(posedge bus.aclk) begin
        if (!bus.aresetn) begin
            user_check_en <= 1'b0;
            trim_check_en <= 1'b0;
            whole_store_check_en <= 1'b0;
            exclude_record_from_check <= 1'b0;
            fault_record_en <= 1'b0;
            fault_record_single <= 1'b0;
            fault_log_value <= 8'h00;
            live_store_read_en <= 1'b0;
            startup_blocked <= 1'b0;
            ontime_limit_active <= 1'b0;
            surge_min_on_time <= 5'h00;
            rectifier_delay_active <= 1'b0;
            rectifier_surge_delay <= 4'h0;
            force_rectifier_on <= 1'b0;
            shutdown_request <= 1'b0;
        end else begin
            user_check_en <= store_ctrl_reg[nvmsc_pkg::USER_CHECK_BIT];
            trim_check_en <= store_ctrl_reg[nvmsc_pkg::TRIM_CHECK_BIT];
            whole_store_check_en <= store_ctrl_reg[nvmsc_pkg::WHOLE_CHECK_BIT];
            exclude_record_from_check <= store_ctrl_reg[nvmsc_pkg::EXCL_RECORD_BIT];
            fault_record_en <= store_ctrl_reg[nvmsc_pkg::RECORD_EN_BIT];
            fault_record_single <= store_ctrl_reg[nvmsc_pkg::RECORD_EN_BIT]
                && store_ctrl_reg[nvmsc_pkg::SINGLE_RECORD_BIT];
            fault_log_value <= log_next;
            live_store_read_en <= store_ctrl_reg[nvmsc_pkg::LIVE_READ_BIT];
            startup_blocked <= store_block_reg || last_block_reg;
            ontime_limit_active <= high_adj || low_adj;
            surge_min_on_time <= {1'b0, spike_ctrl_reg[nvmsc_pkg::MIN_ON_MSB:nvmsc_pkg::MIN_ON_LSB]}
                + 5'h01;
            rectifier_delay_active <= dly_act;
            rectifier_surge_delay <= spike_ctrl_reg[nvmsc_pkg::SR_DELAY_MSB:nvmsc_pkg::SR_DELAY_LSB];
            force_rectifier_on <= force_next;
            shutdown_request <= 1'b0;
        end
    end
endmodule

//--- tb/nvmsc_props.sv
`timescale 1ns/100ps
module nvmsc_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req,
    input wire logic write,
    input wire logic [7:0] cmd,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata
);
    // ****************************************
    // Shadow copies of the two control words
    // ****************************************
    logic [15:0] store_reg;
    logic [15:0] store_next;
    logic [15:0] spike_reg;
    logic [15:0] spike_next;
    always_comb begin
        store_next = store_reg;
        spike_next = spike_reg;
        if (req && !ack && write && cmd == nvmsc_pkg::CMD_STORE_CTRL) begin
            store_next = wdata;
        end
        if (req && !ack && write && cmd == nvmsc_pkg::CMD_SPIKE_CTRL) begin
            spike_next = wdata;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            store_reg <= nvmsc_pkg::STORE_CTRL_RESET;
            spike_reg <= nvmsc_pkg::SPIKE_CTRL_RESET;
        end else begin
            store_reg <= store_next;
            spike_reg <= spike_next;
        end
    end
    // ****************************************
    // Link properties
    // ****************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_take;
        req && !ack;
    endsequence
    sequence s_read(logic [7:0] c);
        req && !ack && !write && cmd == c;
    endsequence
    property p_ack_next;
        s_take |=> ack;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
    property p_ack_pulse;
        ack |=> !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle");
    property p_ack_cause;
        $rose(ack) |-> $past(req);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
    property p_req_release;
        ack |=> !req;
    endproperty
    a_req_release: assert property (p_req_release) else $error("request kept after answer");
    property p_req_held;
        s_take |=> req && $stable(cmd) && $stable(write) && $stable(wdata);
    endproperty
    a_req_held: assert property (p_req_held) else $error("request changed before answer");
    property p_store_back;
        s_read(nvmsc_pkg::CMD_STORE_CTRL) |=> rdata == store_reg;
    endproperty
    a_store_back: assert property (p_store_back) else $error("store word read back wrong");
    property p_spike_back;
        s_read(nvmsc_pkg::CMD_SPIKE_CTRL) |=> rdata == spike_reg;
    endproperty
    a_spike_back: assert property (p_spike_back) else $error("spike word read back wrong");
    property p_unknown_zero;
        s_take ##0 (!write && cmd != nvmsc_pkg::CMD_STORE_CTRL && cmd != nvmsc_pkg::CMD_SPIKE_CTRL
            && cmd != nvmsc_pkg::CMD_CLEAR_LAST_FAULT && cmd != nvmsc_pkg::CMD_CLEAR_STORE_FAULT)
            |=> rdata == 16'h0000;
    endproperty
    a_unknown_zero: assert property (p_unknown_zero) else $error("unknown code read not zero");
    property p_rdata_hold;
        $changed(rdata) |-> ack && !write;
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read word changed outside a read");
endmodule

//--- tb/nvm_and_spike_control_regs_test.sv
`timescale 1ns/100ps
module nvm_and_spike_control_regs_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic store_fault = 1'b0, record_fault_trigger = 1'b0, soft_start = 1'b0, normal_run = 1'b0;
    logic primary_on = 1'b0, rectifier_on = 1'b0, high_input_surge = 1'b0, low_input_surge = 1'b0;
    logic [7:0] last_fault_value = 8'h00, memory_pointer = 8'h5a;
    logic user_check_en, trim_check_en, whole_store_check_en, exclude_record_from_check;
    logic fault_record_en, fault_record_single, live_store_read_en, startup_blocked;
    logic ontime_limit_active, rectifier_delay_active, force_rectifier_on, shutdown_request;
    logic [7:0] fault_log_value;
    logic [4:0] surge_min_on_time;
    logic [3:0] rectifier_surge_delay;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [1:0] irq_mask = 2'h0;
    int bad_count = 0;
    int checks = 0;
    always #20 aclk = ~aclk;
    nvmsc_if link (.aclk(aclk), .aresetn(aresetn));
    nvmsc_device nvmsc_device_inst (.bus(link), .*);
    nvmsc_host nvmsc_host_inst (.bus(link), .*);
    nvmsc_props nvmsc_props_inst (.aclk(aclk), .aresetn(aresetn), .req(link.req), .write(link.write),
        .cmd(link.cmd), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic timed_out();
        bad_count++;
        $display("MISMATCH %0t wait ran out", $time);
        report_and_stop();
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw;
        logic w;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        for (int n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (aw && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw = 1'b0;
            end
            if (w && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w = 1'b0;
            end
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        timed_out();
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        timed_out();
    endtask
    task automatic wait_event(input int b);
        logic [31:0] v;
        logic [1:0] r;
        for (int n = 0; n < 30; n++) begin
            axi_read(nvmsc_pkg::HOST_STATUS_OFS, v, r);
            if (v[b] === 1'b1) begin
                check(irq, irq_mask[b]);
                axi_write(nvmsc_pkg::HOST_STATUS_OFS, 32'h1 << b, r);
                repeat (2) @(posedge aclk);
                check(irq, 1'b0);
                return;
            end
        end
        timed_out();
    endtask
    task automatic link_write(input logic [7:0] c, input logic [15:0] d);
        logic [1:0] r;
        axi_write(nvmsc_pkg::HOST_WDATA_OFS, {16'h0000, d}, r);
        axi_write(nvmsc_pkg::HOST_CMD_OFS, {23'h0, 1'b1, c}, r);
        check(r, nvmsc_pkg::AXI_OKAY);
        wait_event(nvmsc_pkg::EV_WRITE_DONE);
    endtask
    task automatic link_read(input logic [7:0] c, input logic [15:0] e);
        logic [31:0] v;
        logic [1:0] r;
        axi_write(nvmsc_pkg::HOST_CMD_OFS, {24'h0, c}, r);
        wait_event(nvmsc_pkg::EV_READ_DONE);
        axi_read(nvmsc_pkg::HOST_RDATA_OFS, v, r);
        check(v, {16'h0000, e});
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        logic [15:0] w;
        logic [31:0] v;
        logic [1:0] r;
        static logic [15:0] sw [5] = '{16'h8000, 16'h4000, 16'h2020, 16'h000a, 16'h07c5};
        static logic [15:0] kw [4] = '{16'h0000, 16'hffff, 16'h2a55, 16'h7f3a};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        link_read(nvmsc_pkg::CMD_STORE_CTRL, nvmsc_pkg::STORE_CTRL_RESET);
        link_read(nvmsc_pkg::CMD_SPIKE_CTRL, nvmsc_pkg::SPIKE_CTRL_RESET);
        axi_read(8'h18, v, r);
        check(r, nvmsc_pkg::AXI_SLVERR);
        axi_write(8'h1c, 32'h1, r);
        check(r, nvmsc_pkg::AXI_SLVERR);
        axi_write(nvmsc_pkg::HOST_MASK_OFS, 32'h1, r);
        irq_mask = 2'h1;
        $display("test reset and map done");
        foreach (sw[i]) begin
            w = sw[i];
            link_write(nvmsc_pkg::CMD_STORE_CTRL, w);
            link_read(nvmsc_pkg::CMD_STORE_CTRL, w);
            check({user_check_en, trim_check_en, whole_store_check_en, exclude_record_from_check, fault_record_en,
                fault_record_single, live_store_read_en}, {w[15:13], w[5], w[1], w[1] & w[3], w[0]});
        end
        link_write(8'h56, 16'hffff);
        link_read(8'h55, 16'h0000);
        link_read(nvmsc_pkg::CMD_STORE_CTRL, w);
        link_write(nvmsc_pkg::CMD_STORE_CTRL, 16'h0010);
        check(fault_log_value, nvmsc_pkg::FAULT_LOG_CLEAR);
        link_write(nvmsc_pkg::CMD_STORE_CTRL, 16'h0000);
        check(fault_log_value, 8'h5a);
        @(posedge aclk);
        record_fault_trigger <= 1'b1;
        last_fault_value <= 8'h3c;
        repeat (3) @(posedge aclk);
        check(fault_log_value, 8'h3c);
        $display("test store word done");
        irq_mask = 2'h3;
        axi_write(nvmsc_pkg::HOST_MASK_OFS, 32'h3, r);
        store_fault <= 1'b1;
        link_write(nvmsc_pkg::CMD_STORE_CTRL, 16'h0000);
        check(startup_blocked, 1'b0);
        link_write(nvmsc_pkg::CMD_STORE_CTRL, 16'h1000);
        store_fault <= 1'b0;
        repeat (3) @(posedge aclk);
        check(startup_blocked, 1'b1);
        link_write(nvmsc_pkg::CMD_CLEAR_STORE_FAULT, 16'h0000);
        check(startup_blocked, 1'b0);
        link_write(nvmsc_pkg::CMD_STORE_CTRL, 16'h0800);
        last_fault_value <= 8'h00;
        repeat (3) @(posedge aclk);
        check(startup_blocked, 1'b1);
        link_write(nvmsc_pkg::CMD_CLEAR_LAST_FAULT, 16'h0000);
        check(startup_blocked, 1'b0);
        $display("test start-up block done");
        foreach (kw[k]) begin
            w = kw[k];
            link_write(nvmsc_pkg::CMD_SPIKE_CTRL, w);
            link_read(nvmsc_pkg::CMD_SPIKE_CTRL, w);
            for (int c = 0; c < 64; c++) begin
                @(posedge aclk);
                {soft_start, normal_run, high_input_surge, low_input_surge, primary_on, rectifier_on} <= 6'(c);
                repeat (2) @(posedge aclk);
                check(surge_min_on_time, {1'b0, w[11:8]} + 5'h01);
                check(rectifier_surge_delay, w[15:12]);
                check(ontime_limit_active, c[3] & (c[5] ? w[2] : w[1]) | c[2] & !c[5] & w[0]);
                check(rectifier_delay_active, c[3] & (c[5] & w[6] | !c[5] & w[5] | c[4] & w[4] & w[5]));
                check(force_rectifier_on, w[3] & c[1] & !c[0] & (c[3] | c[2]));
                check(shutdown_request, 1'b0);
            end
        end
        $display("test spike word done");
        report_and_stop();
    end
endmodule
